// ### psm_pkg.sv
package psm_pkg;

  typedef struct packed {
    logic [11:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } psm_time_t;

  typedef struct packed {
    logic retain;
    logic bypass;
    logic halt;
  } psm_cfg_t;

  typedef struct packed {
    logic [16:0] baud;
    logic [3:0] data_bits;
    logic parity_en;
    logic [1:0] stop_bits;
  } psm_uart_t;

  typedef struct packed {
    logic clock_err;
    logic pause;
    logic run_err;
  } psm_lamp_t;

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'h0,
    ST_LOAD = 2'h1,
    ST_CLEAR = 2'h3,
    ST_RUN = 2'h2
  } psm_state_t;

  // Timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned LAMP_TEST_MS = 500;
  localparam int unsigned LAMP_TEST_CYC = LAMP_TEST_MS * (CLK_HZ / 1000);
  localparam logic [1:0] SAMPLE_CYC = 2'h3;

  // Memory sizes
  localparam int unsigned DW_BASE_WORDS = 1000;
  localparam int unsigned DW_EXT_WORDS = 4000;
  localparam int unsigned NV_WORDS = 11000;
  localparam logic [15:0] DW_BASE_LIMIT = 16'h03E8;
  localparam logic [15:0] DW_EXT_LIMIT = 16'h0FA0;
  localparam logic [15:0] NV_LIMIT = 16'h2AF8;

  // Switch bank bit positions
  localparam int unsigned SW_RETAIN = 0;
  localparam int unsigned SW_BYPASS = 2;
  localparam int unsigned SW_HALT = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_DW_INDEX = 8'h0C;
  localparam logic [7:0] OFS_DW_DATA = 8'h10;
  localparam logic [7:0] OFS_NV_INDEX = 8'h14;
  localparam logic [7:0] OFS_NV_DATA = 8'h18;
  localparam logic [7:0] OFS_TIME_SET = 8'h1C;
  localparam logic [7:0] OFS_DATE_SET = 8'h20;
  localparam logic [7:0] OFS_TIME = 8'h24;
  localparam logic [7:0] OFS_DATE = 8'h28;

  // Field positions
  localparam int unsigned CTRL_RESYNC_DIS = 0;
  localparam int unsigned CMD_TOGGLE = 0;
  localparam int unsigned CMD_HALT = 1;

  // Reset and boot values
  localparam psm_time_t DEFAULT_TIME = '{12'h7D8, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00};
  localparam psm_uart_t BOOT_UART = '{17'h09600, 4'h8, 1'h0, 2'h1};

endpackage : psm_pkg

// ### psm_sync.sv
`timescale 1ns/1ps
module psm_sync #(
  parameter int unsigned W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : psm_sync

// ### psm_rtc.sv
`timescale 1ns/1ps
module psm_rtc #(
  parameter int unsigned SEC_CYC = psm_pkg::CLK_HZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load,
  input psm_pkg::psm_time_t load_val,
  output psm_pkg::psm_time_t now_q,
  output logic tick_q
);

  logic [26:0] div_q;
  psm_pkg::psm_time_t t;
  wire logic div_end = (div_q == 27'(SEC_CYC - 1));

  function automatic logic [4:0] mdays(input logic [3:0] m, input logic [11:0] y);
    case (m)
      4'h2: mdays = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: mdays = 5'h1E;
      default: mdays = 5'h1F;
    endcase
  endfunction : mdays

  // Calendar carry chain
  always_comb begin
    t = now_q;
    if (t.second != 6'h3B) begin
      t.second = t.second + 6'h1;
    end else begin
      t.second = 6'h0;
      if (t.minute != 6'h3B) begin
        t.minute = t.minute + 6'h1;
      end else begin
        t.minute = 6'h0;
        if (t.hour != 5'h17) begin
          t.hour = t.hour + 5'h1;
        end else begin
          t.hour = 5'h0;
          if (t.day != mdays(t.month, t.year)) begin
            t.day = t.day + 5'h1;
          end else begin
            t.day = 5'h1;
            if (t.month != 4'hC) begin
              t.month = t.month + 4'h1;
            end else begin
              t.month = 4'h1;
              t.year = t.year + 12'h1;
            end
          end
        end
      end
    end
  end

  // Power-up value is the fixed default date
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      now_q <= psm_pkg::DEFAULT_TIME; // [RQ8]
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_end & !load;
      if (load) begin
        now_q <= load_val;
        div_q <= '0;
      end else if (div_end) begin
        now_q <= t;
        div_q <= '0;
      end else begin
        div_q <= div_q + 27'h1;
      end
    end
  end

endmodule : psm_rtc

// ### psm_top.sv
`timescale 1ns/1ps
// What this block does
// [RQ1] Base build: high data words read zero, ignore writes
// [RQ2] Module fitted: 4000 data words available
// [RQ3] Module plus retention switch keeps memory and variables
// [RQ4] No module: clear variables and data at power-up
// [RQ5] Bypass switch skips login and address filtering
// [RQ6] Halt switch stops ladder, keeps host link
// [RQ7] Halt at power-up: both ports 38400 8N1
// [RQ8] No battery clock: start at 2008/1/1 0:00:00
// [RQ9] Detect clock module, load time at start
// [RQ10] Hourly reload from module unless disabled
// [RQ11] All lamps on half second at power-up
// [RQ12] Clock lost: lamp and flag until host sets
// [RQ13] Pause lamp for corrupt, statement, host, switch
// [RQ14] Toggle resumes pause except corrupt or switch
// [RQ15] Module gives 11000 persistent sixteen-bit words
// [RQ16] Switches sampled once after reset, then held
module psm_top #(
  parameter int unsigned LAMP_CYC = psm_pkg::LAMP_TEST_CYC,
  parameter int unsigned SEC_CYC = psm_pkg::CLK_HZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] switch_pins,
  input wire logic module_present_pin,
  input psm_pkg::psm_time_t module_time,
  input wire logic prog_corrupt,
  input wire logic pause_stmt,
  input wire logic rtc_lost,
  output logic security_bypass,
  output logic program_halt,
  output logic ladder_run,
  output logic boot_uart_force,
  output psm_pkg::psm_uart_t boot_uart,
  output psm_pkg::psm_lamp_t lamps,
  output logic clock_lost,
  output logic var_clear,
  output logic io_clear,
  output psm_pkg::psm_time_t time_now
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and switch capture

  logic [3:0] sw_s;
  logic present_s;
  psm_pkg::psm_cfg_t cfg_q;
  logic present_q;
  psm_pkg::psm_state_t st_q, st_d;
  logic [1:0] smp_q;
  logic [11:0] clr_q;

  psm_sync #(.W(5)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({module_present_pin, switch_pins}),
    .sync_out({present_s, sw_s})
  );

  wire logic smp_done = (smp_q == psm_pkg::SAMPLE_CYC);
  wire logic keep_mem = present_q & cfg_q.retain;
  wire logic clr_last = (clr_q == 12'(psm_pkg::DW_EXT_WORDS - 1));

  // Boot sequence
  always_comb begin
    st_d = st_q;
    case (st_q)
      psm_pkg::ST_SAMPLE: if (smp_done) st_d = psm_pkg::ST_LOAD;
      psm_pkg::ST_LOAD: st_d = keep_mem ? psm_pkg::ST_RUN : psm_pkg::ST_CLEAR; // [RQ3] [RQ4]
      psm_pkg::ST_CLEAR: if (clr_last) st_d = psm_pkg::ST_RUN;
      psm_pkg::ST_RUN: st_d = psm_pkg::ST_RUN;
      default: st_d = psm_pkg::ST_SAMPLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= psm_pkg::ST_SAMPLE;
      smp_q <= '0;
      clr_q <= '0;
      cfg_q <= '0;
      present_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == psm_pkg::ST_SAMPLE) begin
        smp_q <= smp_q + 2'h1;
      end
      if (st_q == psm_pkg::ST_CLEAR) begin
        clr_q <= clr_q + 12'h1;
      end
      // Captured once; later switch moves wait for the next reset
      if (st_q == psm_pkg::ST_SAMPLE && smp_done) begin // [RQ16]
        cfg_q.retain <= sw_s[psm_pkg::SW_RETAIN];
        cfg_q.bypass <= sw_s[psm_pkg::SW_BYPASS];
        cfg_q.halt <= sw_s[psm_pkg::SW_HALT];
        present_q <= present_s; // [RQ9]
      end
    end
  end

  wire logic booting = (st_q != psm_pkg::ST_RUN);
  wire logic clr_busy = (st_q == psm_pkg::ST_CLEAR);

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  logic ap_valid_q, ap_write_q, rd_done_q;
  logic [7:0] ap_addr_q;
  logic [31:0] rd_mux;
  logic resync_dis_q;
  logic [15:0] dw_idx_q, nv_idx_q;

  wire logic sel = hsel & htrans[1] & hready;
  // Reads take one wait state so hrdata comes from a flop
  wire logic stall = ap_valid_q & (clr_busy | (!ap_write_q & !rd_done_q));
  wire logic wr_en = ap_valid_q & ap_write_q & !clr_busy;
  wire logic wr_ctrl = wr_en & (ap_addr_q == psm_pkg::OFS_CTRL);
  wire logic wr_cmd = wr_en & (ap_addr_q == psm_pkg::OFS_CMD);
  wire logic wr_dmi = wr_en & (ap_addr_q == psm_pkg::OFS_DW_INDEX);
  wire logic wr_dmd = wr_en & (ap_addr_q == psm_pkg::OFS_DW_DATA);
  wire logic wr_nvi = wr_en & (ap_addr_q == psm_pkg::OFS_NV_INDEX);
  wire logic wr_nvd = wr_en & (ap_addr_q == psm_pkg::OFS_NV_DATA);
  wire logic wr_tset = wr_en & (ap_addr_q == psm_pkg::OFS_TIME_SET);
  wire logic wr_dset = wr_en & (ap_addr_q == psm_pkg::OFS_DATE_SET);
  wire logic cmd_toggle = wr_cmd & hwdata[psm_pkg::CMD_TOGGLE];
  wire logic cmd_halt = wr_cmd & hwdata[psm_pkg::CMD_HALT];

  assign hreadyout = !stall;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= '0;
      rd_done_q <= 1'b0;
      hrdata <= '0;
    end else if (hreadyout) begin
      ap_valid_q <= sel;
      ap_write_q <= hwrite;
      ap_addr_q <= {haddr[7:2], 2'h0};
      rd_done_q <= 1'b0;
    end else if (!clr_busy && !ap_write_q) begin
      rd_done_q <= 1'b1;
      hrdata <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resync_dis_q <= 1'b0;
      dw_idx_q <= '0;
      nv_idx_q <= '0;
    end else begin
      if (wr_ctrl) resync_dis_q <= hwdata[psm_pkg::CTRL_RESYNC_DIS];
      if (wr_dmi) dw_idx_q <= hwdata[15:0];
      if (wr_nvi) nv_idx_q <= hwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data memory and persistent store

  logic [15:0] dw_mem [psm_pkg::DW_EXT_WORDS];
  logic [15:0] nv_mem [psm_pkg::NV_WORDS];

  wire logic [15:0] dw_limit = present_q ? psm_pkg::DW_EXT_LIMIT : psm_pkg::DW_BASE_LIMIT; // [RQ2]
  wire logic dw_ok = (dw_idx_q != 16'h0) & (dw_idx_q <= dw_limit); // [RQ1]
  wire logic [11:0] dw_addr = dw_idx_q[11:0] - 12'h1;
  wire logic nv_ok = present_q & (nv_idx_q < psm_pkg::NV_LIMIT); // [RQ15]
  wire logic [13:0] nv_addr = nv_idx_q[13:0];
  wire logic [15:0] dw_rd = dw_ok ? dw_mem[dw_addr] : 16'h0; // [RQ1]
  wire logic [15:0] nv_rd = nv_ok ? nv_mem[nv_addr] : 16'h0;

  // Sweep only when memory is not held by the module
  always_ff @(posedge hclk) begin
    if (clr_busy) begin
      dw_mem[clr_q] <= 16'h0; // [RQ4]
    end else if (wr_dmd && dw_ok) begin
      dw_mem[dw_addr] <= hwdata[15:0]; // [RQ1]
    end
  end

  // Store persistent word path
  always_ff @(posedge hclk) begin
    if (wr_nvd && nv_ok) begin
      nv_mem[nv_addr] <= hwdata[15:0]; // [RQ15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Real-time clock

  psm_pkg::psm_time_t rtc_now, load_val;
  logic rtc_tick, tick_d_q;

  wire logic boot_load = (st_q == psm_pkg::ST_LOAD) & present_q; // [RQ9]
  wire logic resync = !booting & present_q & !resync_dis_q & tick_d_q & (rtc_now.minute == 6'h0)
                      & (rtc_now.second == 6'h0); // [RQ10]
  wire logic host_set = wr_tset | wr_dset;
  wire logic rtc_load = boot_load | resync | host_set;

  always_comb begin
    load_val = rtc_now;
    if (boot_load || resync) begin
      load_val = module_time;
    end else if (wr_tset) begin
      load_val.hour = hwdata[20:16];
      load_val.minute = hwdata[13:8];
      load_val.second = hwdata[5:0];
    end else if (wr_dset) begin
      load_val.year = hwdata[27:16];
      load_val.month = hwdata[11:8];
      load_val.day = hwdata[4:0];
    end
  end

  psm_rtc #(.SEC_CYC(SEC_CYC)) u_rtc (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(rtc_load),
    .load_val(load_val),
    .now_q(rtc_now),
    .tick_q(rtc_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status, pause and lamps

  logic clock_lost_q, paused_q;
  logic [26:0] lamp_q;

  wire logic hard_pause = prog_corrupt | cfg_q.halt;
  wire logic toggle_ok = cmd_toggle & !hard_pause; // [RQ14]
  wire logic pause_any = paused_q | hard_pause; // [RQ13]
  wire logic lamp_test = (lamp_q != 27'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_d_q <= 1'b0;
      clock_lost_q <= 1'b0;
      paused_q <= 1'b0;
      lamp_q <= 27'(LAMP_CYC); // [RQ11]
      security_bypass <= 1'b0;
      program_halt <= 1'b0;
      ladder_run <= 1'b0;
      boot_uart_force <= 1'b0;
      boot_uart <= '0;
      lamps <= '0;
      var_clear <= 1'b0;
      io_clear <= 1'b0;
      time_now <= psm_pkg::DEFAULT_TIME;
    end else begin
      tick_d_q <= rtc_tick;
      // A loss in the same cycle as a host set wins
      clock_lost_q <= rtc_lost | (clock_lost_q & !host_set); // [RQ12]
      paused_q <= pause_stmt | cmd_halt | (toggle_ok ? !paused_q : paused_q); // [RQ13] [RQ14]
      if (lamp_test) lamp_q <= lamp_q - 27'h1;
      security_bypass <= cfg_q.bypass; // [RQ5]
      program_halt <= cfg_q.halt;
      ladder_run <= !booting & !pause_any; // [RQ6]
      boot_uart_force <= cfg_q.halt; // [RQ7]
      boot_uart <= cfg_q.halt ? psm_pkg::BOOT_UART : '0; // [RQ7]
      lamps.clock_err <= lamp_test | clock_lost_q; // [RQ11] [RQ12]
      lamps.pause <= lamp_test | pause_any; // [RQ11] [RQ13]
      lamps.run_err <= lamp_test; // [RQ11]
      var_clear <= (st_q == psm_pkg::ST_LOAD) & !keep_mem; // [RQ3] [RQ4]
      io_clear <= (st_q == psm_pkg::ST_LOAD) & !cfg_q.retain; // [RQ3]
      time_now <= rtc_now;
    end
  end

  assign clock_lost = clock_lost_q;

  always_comb begin
    rd_mux = 32'h0;
    case (ap_addr_q)
      psm_pkg::OFS_CTRL: rd_mux[psm_pkg::CTRL_RESYNC_DIS] = resync_dis_q;
      psm_pkg::OFS_STATUS: rd_mux[7:0] = {lamp_test, clr_busy, pause_any, clock_lost_q,
                                         cfg_q.halt, cfg_q.bypass, cfg_q.retain, present_q};
      psm_pkg::OFS_DW_INDEX: rd_mux[15:0] = dw_idx_q;
      psm_pkg::OFS_DW_DATA: rd_mux[15:0] = dw_rd;
      psm_pkg::OFS_NV_INDEX: rd_mux[15:0] = nv_idx_q;
      psm_pkg::OFS_NV_DATA: rd_mux[15:0] = nv_rd;
      psm_pkg::OFS_TIME: rd_mux = {11'h0, rtc_now.hour, 2'h0, rtc_now.minute, 2'h0, rtc_now.second};
      psm_pkg::OFS_DATE: rd_mux = {4'h0, rtc_now.year, 4'h0, rtc_now.month, 3'h0, rtc_now.day};
      default: rd_mux = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_DW_HIGH_ZERO: assert property ( // [RQ1]
    ap_valid_q && !ap_write_q && rd_done_q && ap_addr_q == psm_pkg::OFS_DW_DATA && !present_q
    && dw_idx_q > psm_pkg::DW_BASE_LIMIT |-> hrdata == 32'h0)
    else $error("high data word read not zero");
  AST_DW_LIMIT: assert property ( // [RQ2]
    present_q && wr_dmd && dw_idx_q == psm_pkg::DW_EXT_LIMIT
    |=> dw_mem[12'(psm_pkg::DW_EXT_WORDS - 1)] == 16'($past(hwdata)))
    else $error("top data word not stored with module");
  AST_RETAIN_SKIP: assert property ( // [RQ3]
    st_q == psm_pkg::ST_LOAD && keep_mem |=> st_q == psm_pkg::ST_RUN && !var_clear)
    else $error("retained memory was cleared");
  AST_CLEAR_ABSENT: assert property ( // [RQ4]
    st_q == psm_pkg::ST_LOAD && !present_q |=> clr_busy && var_clear)
    else $error("no clear without module");
  AST_BYPASS: assert property ( // [RQ5]
    !booting |-> ##1 security_bypass == $past(cfg_q.bypass))
    else $error("bypass output mismatch");
  AST_HALT_STOP: assert property ( // [RQ6]
    cfg_q.halt |=> !ladder_run)
    else $error("ladder runs under halt switch");
  AST_BOOT_BAUD: assert property ( // [RQ7]
    cfg_q.halt |=> boot_uart_force && boot_uart.baud == 17'h09600 && boot_uart.data_bits == 4'h8)
    else $error("boot port format wrong");
  AST_DEFAULT_DATE: assert property ( // [RQ8]
    st_q == psm_pkg::ST_SAMPLE |-> rtc_now == psm_pkg::DEFAULT_TIME)
    else $error("clock not at default date");
  AST_BOOT_LOAD: assert property ( // [RQ9]
    boot_load |=> rtc_now == $past(module_time))
    else $error("clock not loaded from module");
  AST_HOURLY: assert property ( // [RQ10]
    resync |-> present_q && !resync_dis_q ##1 rtc_now == $past(module_time))
    else $error("hourly reload wrong");
  AST_LAMP_TEST: assert property ( // [RQ11]
    lamp_test |=> lamps.clock_err && lamps.pause && lamps.run_err)
    else $error("lamp test not all lit");
  AST_CLOCK_LOST: assert property ( // [RQ12]
    rtc_lost |=> clock_lost ##1 lamps.clock_err)
    else $error("clock lost not shown");
  AST_PAUSE_LAMP: assert property ( // [RQ13]
    hard_pause |=> lamps.pause)
    else $error("pause lamp off");
  AST_TOGGLE_BLOCK: assert property ( // [RQ14]
    cmd_toggle && hard_pause && paused_q |=> paused_q)
    else $error("toggle released a locked pause");
  AST_NV_GATE: assert property ( // [RQ15]
    ap_valid_q && rd_done_q && ap_addr_q == psm_pkg::OFS_NV_DATA && !present_q |-> hrdata == 32'h0)
    else $error("persistent store visible without module");
  AST_CFG_HELD: assert property ( // [RQ16]
    !booting && !$past(booting) |-> $stable(cfg_q))
    else $error("switch settings changed after boot");

  COV_CLEAR: cover property (st_q == psm_pkg::ST_CLEAR ##1 st_q == psm_pkg::ST_RUN);
  COV_RESYNC: cover property (resync);
  COV_RESUME: cover property (paused_q && toggle_ok ##1 !paused_q);
  COV_LAMP_END: cover property (lamp_test ##1 !lamp_test);

endmodule : psm_top

// ### psm_addon_model.sv
`timescale 1ns/1ps
module psm_addon_model (
  input wire logic fitted,
  output logic module_present_pin,
  output psm_pkg::psm_time_t module_time
);
  // Battery clock held still: a run lasts far less than one module second
  assign module_present_pin = fitted;
  // Unplugged connector floats, so show all ones, never a stale time
  assign module_time = fitted ? psm_pkg::psm_time_t'({12'h7E4, 4'h6, 5'h0F, 5'h07, 6'h00, 6'h00}) : '1;
endmodule : psm_addon_model

// ### psm_top_tb.sv
`timescale 1ns/1ps
module psm_top_tb;
  localparam int unsigned LAMP_CYC = 20;
  localparam int unsigned SEC_CYC = 10;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] switch_pins;
  logic fitted, module_present_pin, prog_corrupt, pause_stmt, rtc_lost;
  logic security_bypass, program_halt, ladder_run, boot_uart_force, clock_lost, var_clear, io_clear;
  psm_pkg::psm_time_t module_time, time_now;
  psm_pkg::psm_uart_t boot_uart;
  psm_pkg::psm_lamp_t lamps;
  int errors, total_checks, cycles, n_vclr, n_ioclr;

  assign hready = hreadyout;

  psm_top #(.LAMP_CYC(LAMP_CYC), .SEC_CYC(SEC_CYC)) u_psm_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .switch_pins(switch_pins), .module_present_pin(module_present_pin),
    .module_time(module_time), .prog_corrupt(prog_corrupt), .pause_stmt(pause_stmt),
    .rtc_lost(rtc_lost), .security_bypass(security_bypass), .program_halt(program_halt),
    .ladder_run(ladder_run), .boot_uart_force(boot_uart_force), .boot_uart(boot_uart),
    .lamps(lamps), .clock_lost(clock_lost), .var_clear(var_clear), .io_clear(io_clear),
    .time_now(time_now));

  psm_addon_model u_psm_addon_model (.fitted(fitted), .module_present_pin(module_present_pin),
    .module_time(module_time));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      errors++;
    end
  endtask : chk

  // Single word transfer; waits only on hready, the timeout ends a hang
  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= {24'h000000, ofs};
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer

  task automatic idx_xfer(input logic [7:0] ofs, input logic [31:0] idx, input logic wr, input logic [31:0] d);
    xfer(1'b1, ofs, idx);
    xfer(wr, ofs + 8'h04, d);
  endtask : idx_xfer

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : settle

  // Power cycle; counts boot clear pulses until the boot sweep is over
  task automatic rst(input logic [3:0] sw, input logic fit);
    @(posedge hclk);
    hresetn <= 1'b0;
    switch_pins <= sw;
    fitted <= fit;
    repeat (6) @(posedge hclk);
    n_vclr = 0;
    n_ioclr = 0;
    hresetn <= 1'b1;
    settle(1);
    chk({29'h0, lamps}, 32'h7);
    settle(8);
    xfer(1'b0, psm_pkg::OFS_STATUS, 32'h0);
    chk({28'h0, rd[3:0]}, {28'h0, sw[3:2], sw[0], fit});
  endtask : rst

  task automatic pulse(input int which);
    @(posedge hclk);
    if (which == 0) rtc_lost <= 1'b1;
    else pause_stmt <= 1'b1;
    @(posedge hclk);
    rtc_lost <= 1'b0;
    pause_stmt <= 1'b0;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles++;
    if (var_clear === 1'b1) n_vclr++;
    if (io_clear === 1'b1) n_ioclr++;
    if (cycles == 40000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    switch_pins = 4'h0;
    fitted = 1'b0;
    prog_corrupt = 1'b0;
    pause_stmt = 1'b0;
    rtc_lost = 1'b0;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    // Base build, no switches
    rst(4'h0, 1'b0);
    settle(LAMP_CYC);
    chk({29'h0, lamps}, 32'h0);
    chk({n_vclr[15:0], n_ioclr[15:0]}, {16'h1, 16'h1});
    chk({ladder_run, boot_uart_force, 24'(boot_uart)}, 32'h2000000);
    xfer(1'b0, psm_pkg::OFS_DATE, 32'h0);
    chk(rd, 32'h07D80101);
    chk({hresp, 3'h0, time_now.year, 4'h0, time_now.month, 3'h0, time_now.day}, 32'h07D80101);
    xfer(1'b0, psm_pkg::OFS_TIME, 32'h0);
    chk({27'h0, rd[20:16]}, 32'h0);
    idx_xfer(psm_pkg::OFS_DW_INDEX, 32'd1000, 1'b1, 32'hA5A5);
    idx_xfer(psm_pkg::OFS_DW_INDEX, 32'd1000, 1'b0, 32'h0);
    chk({16'h0, rd[15:0]}, 32'hA5A5);
    idx_xfer(psm_pkg::OFS_DW_INDEX, 32'd1001, 1'b1, 32'h1234);
    idx_xfer(psm_pkg::OFS_DW_INDEX, 32'd1001, 1'b0, 32'h0);
    chk(rd, 32'h0);
    idx_xfer(psm_pkg::OFS_DW_INDEX, 32'd5, 1'b0, 32'h0);
    chk(rd, 32'h0);
    idx_xfer(psm_pkg::OFS_NV_INDEX, 32'd0, 1'b1, 32'h55);
    idx_xfer(psm_pkg::OFS_NV_INDEX, 32'd0, 1'b0, 32'h0);
    chk(rd, 32'h0);
    // Clock loss then host sets the date
    pulse(0);
    settle(2);
    chk({clock_lost, lamps.clock_err}, 2'h3);
    xfer(1'b1, psm_pkg::OFS_DATE_SET, 32'h07D80101);
    settle(3);
    chk({clock_lost, lamps.clock_err}, 2'h0);
    // Pause causes and the toggle
    pulse(1);
    settle(3);
    chk({lamps.pause, ladder_run}, 2'h2);
    xfer(1'b1, psm_pkg::OFS_CMD, 32'h1);
    settle(3);
    chk({lamps.pause, ladder_run}, 2'h1);
    xfer(1'b1, psm_pkg::OFS_CMD, 32'h2);
    settle(3);
    chk({31'h0, lamps.pause}, 32'h1);
    xfer(1'b1, psm_pkg::OFS_CMD, 32'h1);
    settle(3);
    chk({31'h0, lamps.pause}, 32'h0);
    // Paused, then a corrupt program must lock the pause against the toggle
    pulse(1);
    @(posedge hclk);
    prog_corrupt <= 1'b1;
    xfer(1'b1, psm_pkg::OFS_CMD, 32'h1);
    settle(3);
    chk({lamps.pause, ladder_run}, 2'h2);
    @(posedge hclk);
    prog_corrupt <= 1'b0;
    settle(3);
    chk({31'h0, lamps.pause}, 32'h1);
    // Halt and bypass switches, then switches moved after boot
    rst(4'hC, 1'b0);
    xfer(1'b1, psm_pkg::OFS_CMD, 32'h1);
    @(posedge hclk);
    switch_pins <= 4'h0;
    settle(8);
    chk({security_bypass, program_halt, ladder_run, lamps.pause}, 4'hD);
    chk({boot_uart_force, 24'(boot_uart)}, {1'b1, 17'h09600, 4'h8, 1'b0, 2'h1});
    // Module fitted with retention
    rst(4'h1, 1'b1);
    chk({n_vclr[15:0], n_ioclr[15:0]}, {16'h0, 16'h0});
    xfer(1'b0, psm_pkg::OFS_DATE, 32'h0);
    chk(rd, 32'h07E4060F);
    idx_xfer(psm_pkg::OFS_DW_INDEX, 32'd4000, 1'b1, 32'hBEEF);
    idx_xfer(psm_pkg::OFS_NV_INDEX, 32'd10999, 1'b1, 32'h1234);
    idx_xfer(psm_pkg::OFS_NV_INDEX, 32'd10999, 1'b0, 32'h0);
    chk({16'h0, rd[15:0]}, 32'h1234);
    idx_xfer(psm_pkg::OFS_NV_INDEX, 32'd11000, 1'b0, 32'h0);
    chk(rd, 32'h0);
    rst(4'h1, 1'b1);
    idx_xfer(psm_pkg::OFS_DW_INDEX, 32'd4000, 1'b0, 32'h0);
    chk({16'h0, rd[15:0]}, 32'hBEEF);
    // Hourly reload, then with reload disabled
    xfer(1'b1, psm_pkg::OFS_TIME_SET, 32'h00033B3B);
    settle(3 * SEC_CYC);
    xfer(1'b0, psm_pkg::OFS_TIME, 32'h0);
    chk({21'h0, rd[20:16], rd[13:8]}, {21'h0, 5'h07, 6'h00});
    xfer(1'b1, psm_pkg::OFS_CTRL, 32'h1);
    xfer(1'b0, psm_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    xfer(1'b1, psm_pkg::OFS_TIME_SET, 32'h00033B3B);
    settle(3 * SEC_CYC);
    xfer(1'b0, psm_pkg::OFS_TIME, 32'h0);
    chk({21'h0, rd[20:16], rd[13:8]}, {21'h0, 5'h04, 6'h00});
    // Module fitted, retention off: memory swept
    rst(4'h0, 1'b1);
    chk({n_vclr[15:0], n_ioclr[15:0]}, {16'h1, 16'h1});
    idx_xfer(psm_pkg::OFS_DW_INDEX, 32'd4000, 1'b0, 32'h0);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule : psm_top_tb
